// File: pmsel_defines.svh
`ifndef PMSEL_DEFINES_SVH
`define PMSEL_DEFINES_SVH

// register byte addresses (offsets 0x05/0x06 are not word multiples)
`define PMSEL_IDX_MODE       8'h05
`define PMSEL_IDX_TGT_ID     8'h06
`define PMSEL_ADDR_MODE      12'h014
`define PMSEL_ADDR_TGT_ID    12'h018

// mode register fields
`define PMSEL_BIT_OVERRIDE   5
`define PMSEL_BIT_CURRENT    4
`define PMSEL_BIT_STAT12     3
`define PMSEL_BIT_STAT10     2
`define PMSEL_BIT_TX12       1
`define PMSEL_BIT_TX10       0

// identifier register fields
`define PMSEL_BIT_HOLD       0
`define PMSEL_ID_LSB         1
`define PMSEL_ID_MSB         7

// reset values
`define PMSEL_RST_MODE       8'h00
`define PMSEL_RST_ID         7'h00

`endif

// File: pmsel_pkg.sv
package pmsel_pkg;

    typedef enum logic [1:0] {
        PMSEL_W_NONE,
        PMSEL_W_TEN,
        PMSEL_W_TWELVE
    } pmsel_width_t;

endpackage : pmsel_pkg

// File: pmsel_regs.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
// Summary of operation
// - override bit selects local mode over remote
// - bit 4 shows remote mode is current
// - bit 3 shows remote twelve-bit selection
// - bit 2 shows remote ten-bit selection
// - bit 1 enables twelve-bit bus under override
// - bit 0 enables ten-bit bus under override
// - hold seven-bit remote target identifier
// - zero identifier blocks remote access
// - identifier auto-loads after receiver lock
// - freeze bit suppresses automatic identifier load
`include "pmsel_defines.svh"

module pmsel_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        remote_width_current,
    input  wire logic        remote_sel_twelve,
    input  wire logic        remote_sel_ten,
    input  wire logic        rx_lock,
    input  wire logic [6:0]  bc_target_id,
    output logic             tx_twelve_bit_bus,
    output logic             tx_ten_bit_bus,
    output pmsel_pkg::pmsel_width_t tx_width,
    output logic      [6:0]  remote_target_id,
    output logic             remote_access_enable
);

    // bus side registers
    // write pending, captured address, read data
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;

    // mode register storage, bits 5, 1 and 0
    // bits 4 to 2 are live status, not stored
    logic        override_q;
    logic        override_d;
    logic        tx_twelve_bit_enable_q;
    logic        tx_twelve_bit_enable_d;
    logic        tx_ten_bit_enable_q;
    logic        tx_ten_bit_enable_d;

    // identifier register storage
    // seven identifier bits plus the freeze bit
    logic [6:0]  id_q;
    logic [6:0]  id_d;
    logic        hold_remote_target_id_q;
    logic        hold_remote_target_id_d;

    // receiver lock edge detector
    // starts low so lock held at reset still loads
    logic        lock_q;
    logic        lock_d;

    // transfer qualification and address match
    // read and write decode use different phases
    wire         addr_ok;
    wire         wr_take;
    wire         rd_take;
    wire         hit_mode_rd;
    wire         hit_id_rd;
    wire         hit_mode_wr;
    wire         hit_id_wr;
    wire         wr_mode;
    wire         wr_id;

    // write data fields
    // named slices of hwdata
    wire         wdata_override;
    wire         wdata_tx12;
    wire         wdata_tx10;
    wire [6:0]   wdata_id;
    wire         wdata_hold;

    // selection and identifier control
    // combinational, no extra latency
    wire         lock_rise;
    wire         auto_load;
    wire         sel12;
    wire         sel10;

    // read views
    // low byte only, upper bits always zero
    wire [1:0]   rsvd_rd;
    wire [7:0]   mode_rd;
    wire [7:0]   id_rd;
    wire [31:0]  rd_mux;

    // a transfer is taken only while hready is high
    // sequential and nonsequential treated alike
    assign addr_ok     = hsel && hready && htrans[1];
    assign wr_take     = addr_ok && hwrite;
    assign rd_take     = addr_ok && !hwrite;

    // read decode on the live address phase
    // so read data stands for the whole data phase
    assign hit_mode_rd = (haddr == `PMSEL_ADDR_MODE);
    assign hit_id_rd   = (haddr == `PMSEL_ADDR_TGT_ID);

    // write decode on the captured address
    // haddr may already hold the next transfer
    assign hit_mode_wr = (addr_q == `PMSEL_ADDR_MODE);
    assign hit_id_wr   = (addr_q == `PMSEL_ADDR_TGT_ID);
    assign wr_mode     = wr_pend_q && hit_mode_wr;
    assign wr_id       = wr_pend_q && hit_id_wr;

    // hwdata stands in the data phase only
    // sliced here so the next values stay short
    assign wdata_override = hwdata[`PMSEL_BIT_OVERRIDE];
    assign wdata_tx12     = hwdata[`PMSEL_BIT_TX12];
    assign wdata_tx10     = hwdata[`PMSEL_BIT_TX10];
    assign wdata_id       = hwdata[`PMSEL_ID_MSB:`PMSEL_ID_LSB];
    assign wdata_hold     = hwdata[`PMSEL_BIT_HOLD];

    // auto load on a lock rise unless frozen
    // a lock held high loads only once
    assign lock_rise = rx_lock && !lock_q;
    assign auto_load = lock_rise && !hold_remote_target_id_q;

    // remote selection unless override set
    // local bits ignored while override is clear
    assign sel12 = override_q ? tx_twelve_bit_enable_q
                              : remote_sel_twelve;
    assign sel10 = override_q ? tx_ten_bit_enable_q
                              : remote_sel_ten;

    // reserved bits read zero, writes to them dropped
    assign rsvd_rd = 2'b00;

    // mode register read view
    // status bits show remote selection always
    assign mode_rd = {rsvd_rd,
                      override_q,
                      remote_width_current,
                      remote_sel_twelve,
                      remote_sel_ten,
                      tx_twelve_bit_enable_q,
                      tx_ten_bit_enable_q};

    // identifier register read view
    assign id_rd   = {id_q, hold_remote_target_id_q};

    // unmapped addresses read zero
    assign rd_mux  = hit_mode_rd ? {24'h00_0000, mode_rd} :
                     hit_id_rd   ? {24'h00_0000, id_rd}
                                 : 32'h0000_0000;

    // zero wait state, always okay
    // every transfer ends in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // effective bus selection
    assign tx_twelve_bit_bus = sel12;
    assign tx_ten_bit_bus    = sel10;

    // twelve wins if both set (software breaking the 10/01 pattern)
    assign tx_width = sel12 ? pmsel_pkg::PMSEL_W_TWELVE :
                      sel10 ? pmsel_pkg::PMSEL_W_TEN
                            : pmsel_pkg::PMSEL_W_NONE;

    // identifier outputs
    // zero identifier keeps remote access shut
    assign remote_target_id     = id_q;
    assign remote_access_enable = (id_q != 7'h00);

    // bus side next values
    // read data held until the next read
    assign wr_pend_d = wr_take;
    assign addr_d    = haddr;
    assign lock_d    = rx_lock;
    assign hrdata_d  = rd_take ? rd_mux : hrdata_q;

    // mode fields change only on a mode write
    // status and reserved bits of the word dropped
    assign override_d             = wr_mode ? wdata_override
                                            : override_q;
    assign tx_twelve_bit_enable_d = wr_mode ? wdata_tx12
                                            : tx_twelve_bit_enable_q;
    assign tx_ten_bit_enable_d    = wr_mode ? wdata_tx10
                                            : tx_ten_bit_enable_q;

    // software write wins over a same-cycle auto load
    // keeps a written identifier from being lost
    assign id_d = wr_id     ? wdata_id     :
                  auto_load ? bc_target_id
                            : id_q;
    assign hold_remote_target_id_d = wr_id ? wdata_hold
                                           : hold_remote_target_id_q;

    // write pending flag
    // marks the data phase of a taken write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
        end
    end

    // captured address
    // only used while the write flag is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 12'h000;
        end else begin
            addr_q <= addr_d;
        end
    end

    // read data register
    // loaded at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    // lock history
    // one cycle delayed copy for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    // override bit
    // clear at reset: remote selection in charge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            override_q <= 1'b0;
        end else begin
            override_q <= override_d;
        end
    end

    // local twelve-bit enable
    // only felt while override is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_twelve_bit_enable_q <= 1'b0;
        end else begin
            tx_twelve_bit_enable_q <= tx_twelve_bit_enable_d;
        end
    end

    // local ten-bit enable
    // only felt while override is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ten_bit_enable_q <= 1'b0;
        end else begin
            tx_ten_bit_enable_q <= tx_ten_bit_enable_d;
        end
    end

    // remote identifier
    // zero at reset, remote access blocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_q <= `PMSEL_RST_ID;
        end else begin
            id_q <= id_d;
        end
    end

    // freeze bit
    // set by software to keep its own identifier
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_remote_target_id_q <= 1'b0;
        end else begin
            hold_remote_target_id_q <= hold_remote_target_id_d;
        end
    end

endmodule : pmsel_regs

// File: pmsel_far_model.sv
`timescale 1ns/100ps
module pmsel_far_model (
    input  wire logic        hclk,
    input  wire logic [10:0] cmd,
    output logic      [10:0] far = 11'h055
);
    // id lines toggle while the link is down
    always @(posedge hclk)
        far <= {cmd[10:7], cmd[10] ? cmd[6:0] : ~far[6:0]};
endmodule : pmsel_far_model

// File: pmsel_regs_checker.sv
`timescale 1ns/100ps
module pmsel_regs_checker (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic                    hsel,
    input wire logic                    rx_lock,
    input wire logic                    tx_twelve_bit_bus,
    input wire logic                    tx_ten_bit_bus,
    input wire logic                    remote_access_enable,
    input wire logic [31:0]             hrdata,
    input wire logic [6:0]              remote_target_id,
    input wire pmsel_pkg::pmsel_width_t tx_width
);
    wire [1:0] t = {tx_twelve_bit_bus, tx_ten_bit_bus};
    wire z = remote_access_enable == |remote_target_id;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_ready: assert property (hreadyout) else $error("rdy");
    a_bus_okay: assert property (!hresp) else $error("rsp");
    a_upper_zero: assert property (!hrdata[31:8]) else $error("hi");
    a_zero_blocks: assert property (z) else $error("acc");
    a_sel_twelve: assert property (t[1] |-> tx_width == 2'h2)
        else $error("w12");
    a_sel_ten: assert property (t == 2'h1 |-> tx_width == 2'h1)
        else $error("w10");
    a_sel_none: assert property (!t |-> !tx_width) else $error("w0");
    a_id_cause: assert property ($changed(remote_target_id) |->
        $past(hsel,2) || $past(rx_lock) && !$past(rx_lock,2)) else $error("id");
endmodule : pmsel_regs_checker
bind pmsel_regs pmsel_regs_checker u_chk (.hclk, .hresetn, .hreadyout,
    .hresp, .hsel, .rx_lock, .tx_twelve_bit_bus, .tx_ten_bit_bus,
    .remote_access_enable, .hrdata, .remote_target_id, .tx_width);

// File: pmsel_regs_tb.sv
`timescale 1ns/100ps
module pmsel_regs_tb;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ph = 1'h0;
    logic hready, tx_twelve_bit_bus, tx_ten_bit_bus, remote_access_enable;
    logic [1:0] htrans = 2'h0;
    logic [6:0] remote_target_id;
    logic [10:0] cmd = 11'h000, far;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, exp_q[$];
    int failures = 0, samples_checked = 0, cyc = 0, seed = 60;
    always #5 hclk = ~hclk;
    pmsel_far_model far_side (.hclk, .cmd, .far);
    pmsel_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(),
        .rx_lock(far[10]), .remote_width_current(far[9]),
        .remote_sel_twelve(far[8]), .remote_sel_ten(far[7]),
        .bc_target_id(far[6:0]), .tx_twelve_bit_bus, .tx_ten_bit_bus,
        .tx_width(), .remote_target_id, .remote_access_enable);
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        failures += (got !== exp);
    endtask : cmp
    // reads queue d as the expected data
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'h1, 2'h2, a, w};
        do @(posedge hclk); while (!hready);
        {hsel, htrans, hwdata, ph} <= {1'h0, 2'h0, d, !w};
        do @(posedge hclk); while (!hready);
        ph <= 1'h0;
    endtask : bus
    task wrap_up;
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge hclk) begin
        if (ph) cmp(hrdata, exp_q.pop_front());
        if (++cyc > 2000) failures++;
        if (cyc > 2000) wrap_up();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        cmd[6:0] <= 7'($random(seed)) | 7'h02;
        for (int i = 0; i < 3; i++) begin
            cmd[10:7] <= {2'h3, 2'(i)};
            bus(1'h0, 12'h014, 32'(16 + 4 * i));
            cmp({tx_twelve_bit_bus, tx_ten_bit_bus}, 32'(i));
        end
        cmp({remote_access_enable, remote_target_id}, {1'h1, cmd[6:0]});
        bus(1'h1, 12'h014, 32'h0000_00e1);
        bus(1'h0, 12'h014, 32'h0000_0039);
        cmp({tx_twelve_bit_bus, tx_ten_bit_bus}, 2'h1);
        bus(1'h1, 12'h014, 32'h0000_0022);
        bus(1'h0, 12'h014, 32'h0000_003a);
        cmp({tx_twelve_bit_bus, tx_ten_bit_bus}, 2'h2);
        $display("mode test done");
        bus(1'h1, 12'h018, 32'h0000_0001);
        cmd <= 11'h200;
        bus(1'h0, 12'h018, 32'h0000_0001);
        cmp({remote_access_enable, remote_target_id}, 8'h00);
        cmd <= 11'h77f;
        bus(1'h0, 12'h01c, 32'h0000_0000);
        cmp(remote_target_id, 7'h00);
        $display("id test done");
        wrap_up();
    end
endmodule : pmsel_regs_tb
